// ===== bench/ecp_periph_model.sv
// Purpose: peripheral stand-in on the data and status pins
// Assumes: the port drives the data lines only while its enable is high
// Notes:   released lines carry the peripheral's own byte, never the last host value
`timescale 1ns/1ps
module ecp_periph_model
  import ecp_port_pkg::*;
(
  // pins seen from the port
  input  wire logic [7:0] pins_out,
  input  wire logic       pins_oe,
  input  ctl_pins_t       ctl_out,
  // pins driven back
  output logic [7:0]      pins_in,
  output status_pins_t    status
);
  // wired data bus: port wins while driving, else peripheral byte
  assign pins_in = pins_oe ? pins_out : 8'ha5;
  // busy follows a low strobe; ack, paper end, select and fault stay quiet
  assign status = {~ctl_out.strobe, 4'b1011};
endmodule // ecp_periph_model

// ===== bench/ecp_regs_assertions.sv
// Purpose: port-level checks of the ecp register set
// Assumes: mode tracked from host writes to the extended control register
// Notes:   reads in the stretch cycle are left out, the design ignores them
`timescale 1ns/1ps
module ecp_regs_assertions
  import ecp_port_pkg::*;
(
  // clock, reset and strobes
  input wire logic       sys_clk, rst, host_rd, host_wr, port_dma_grant,
  // host data
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_wdata, host_rdata, port_data_pins_in,
  // levels and enables
  input wire logic       iochrdy_low, port_dma_request, port_dma_request_oe, ecp_enable,
  input wire logic       aux_setup_bit5, irq_line_five_sel, irq_pin_level, clk_frozen,
  input wire logic       port_data_pins_oe,
  input wire logic [1:0] setup_config_one,
  input ctl_pins_t       ctl_out, ctl_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [2:0] mode_q;
  logic       rd_ok;
  // a read the register port really takes
  assign rd_ok = host_rd && ecp_enable && !port_dma_grant && !iochrdy_low;
  // shadow of the mode field
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) mode_q <= 3'h0;
    else if (host_wr && ecp_enable && !port_dma_grant && host_addr == OFF_EXTCTL)
      mode_q <= host_wdata[7:5];
  end
  a_ready_cause: assert property (iochrdy_low |->
    $past(host_rd) && $past(host_addr) == OFF_EXTCTL ##1 !iochrdy_low) else $error("bad stretch");
  a_req_float: assert property (!port_dma_request_oe |-> !port_dma_request)
    else $error("dma request driven while floated");
  a_off_quiet: assert property (!ecp_enable |=> !port_data_pins_oe && !port_dma_request_oe)
    else $error("outputs active while disabled");
  a_od_levels: assert property (mode_q < 3'h2 && $past(mode_q) < 3'h2 |->
    (ctl_oe & ctl_out) == 4'h0) else $error("control pin driven high in open-drain mode");
  a_cfga_image: assert property (rd_ok && !clk_frozen && mode_q == 3'h7 &&
    host_addr == OFF_FIFO |=> host_rdata == {4'h1, $past(aux_setup_bit5), 3'h4})
    else $error("config a image wrong");
  a_cfgb_image: assert property (rd_ok && mode_q == 3'h7 && host_addr == OFF_CFGB |=>
    host_rdata == {1'b0, $past(irq_pin_level), {2{$past(irq_line_five_sel)}}, 2'b10,
    $past(setup_config_one)}) else $error("config b image wrong");
  a_cfgb_closed: assert property (rd_ok && mode_q != 3'h7 && host_addr == OFF_CFGB |=>
    host_rdata == UNDEF_READ) else $error("config b readable outside mode 111");
  a_data_live: assert property (rd_ok && mode_q < 3'h2 && host_addr == OFF_DATA |=>
    host_rdata == $past(port_data_pins_in)) else $error("data read not from pins");
endmodule // ecp_regs_assertions
bind ecp_parallel_port_registers ecp_regs_assertions chk_u (
  .sys_clk, .rst, .host_rd, .host_wr, .port_dma_grant, .host_addr, .host_wdata, .host_rdata,
  .port_data_pins_in, .iochrdy_low, .port_dma_request, .port_dma_request_oe, .ecp_enable,
  .aux_setup_bit5, .irq_line_five_sel, .irq_pin_level, .clk_frozen, .port_data_pins_oe,
  .setup_config_one, .ctl_out, .ctl_oe
);

// ===== bench/tb.sv
// Purpose: register-level bench of the ecp port registers
// Assumes: peripheral model on the pins, dma grant idle
// Notes:   reads wait one more cycle while the ready line is held low
`timescale 1ns/1ps
module tb;
  import ecp_port_pkg::*;
  logic       sys_clk = 1'b0, rst = 1'b1, host_rd = 1'b0, host_wr = 1'b0, clk_frozen = 1'b0;
  logic       ecp_enable = 1'b1, aux_setup_bit5 = 1'b1, irq_line_five_sel = 1'b1;
  logic [1:0] setup_config_one = 2'b10;
  logic [2:0] host_addr = 3'h0;
  logic [7:0] host_wdata = 8'h00, host_rdata, pins_in, pins_out, d;
  logic       iochrdy_low, dma_req, dma_oe, pins_oe, irq_p, ack_p;
  status_pins_t st;
  ctl_pins_t  ctl_out, ctl_oe;
  int         fails = 0, n_checks = 0;
  ecp_parallel_port_registers dut_u (.sys_clk, .rst, .host_addr, .host_rd, .host_wr,
    .host_wdata, .host_rdata, .iochrdy_low, .port_dma_grant(1'b0), .dma_tc(1'b0),
    .port_dma_request(dma_req), .port_dma_request_oe(dma_oe), .ecp_enable,
    .port_cfg_push_pull(1'b0), .port_cfg_level_irq(1'b0), .aux_setup_bit5,
    .setup_config_one, .irq_line_five_sel, .irq_pin_level(1'b0), .clk_frozen,
    .port_data_pins_in(pins_in), .port_data_pins_out(pins_out), .port_data_pins_oe(pins_oe),
    .status_in(st), .ctl_out, .ctl_oe, .ecp_irq_pulse(irq_p), .ack_irq_pending(ack_p));
  ecp_periph_model pm_u (.pins_out, .pins_oe, .ctl_out, .pins_in, .status(st));
  initial forever #20 sys_clk = ~sys_clk;
  // one host write, strobe held for the taking edge only
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk) begin host_addr <= a; host_wdata <= v; host_wr <= 1'b1; end
    @(posedge sys_clk) host_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk) begin host_addr <= a; host_rd <= 1'b1; end
    @(posedge sys_clk) host_rd <= 1'b0;
    #1 if (iochrdy_low === 1'b1) @(posedge sys_clk) #1;
    v = host_rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask
  task test_done;
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog, far beyond the hundred-odd cycles the sequence needs
  initial begin
    repeat (4000) @(posedge sys_clk);
    fails++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rc(OFF_EXTCTL, 8'h15);
    // test mode: overfill, drain all but one in order, then underflow after a mode 000 reset
    wr(OFF_EXTCTL, 8'hd4);
    for (int i = 0; i <= FIFO_DEPTH; i++) wr(OFF_FIFO, 8'(8'h40 + i));
    rc(OFF_EXTCTL, 8'hd6);
    for (int i = 0; i < FIFO_DEPTH - 1; i++) rc(OFF_FIFO, 8'(8'h40 + i));
    wr(OFF_EXTCTL, 8'h14);
    rc(OFF_EXTCTL, 8'h15);
    wr(OFF_EXTCTL, 8'hd0);
    @(posedge sys_clk) #1 chk({7'h0, irq_p}, 8'h01);
    rc(OFF_FIFO, 8'hff);
    rc(OFF_EXTCTL, 8'hd5);
    @(posedge sys_clk) clk_frozen <= 1'b1;
    rc(OFF_EXTCTL, 8'hd3);
    @(posedge sys_clk) clk_frozen <= 1'b0;
    // configuration mode, writes to config a dropped
    wr(OFF_EXTCTL, 8'hf4);
    wr(OFF_FIFO, 8'h00);
    rc(OFF_FIFO, 8'h1c);
    rc(OFF_CFGB, 8'h3a);
    // standard mode: latch readback, direction ignored, pins driven; mode 001 then releases them
    wr(OFF_EXTCTL, 8'h14);
    rc(OFF_CFGB, 8'hff);
    wr(OFF_CONTROL, 8'h21);
    rc(OFF_CONTROL, 8'he1);
    wr(OFF_DATA, 8'h5a);
    rc(OFF_DATA, 8'h5a);
    wr(OFF_EXTCTL, 8'h34);
    rc(OFF_DATA, 8'ha5);
    chk({7'h0, pins_oe}, 8'h00);
    wr(OFF_STATUS, 8'hff);
    rd(OFF_STATUS, d);
    chk(d & 8'h07, 8'h00);
    wr(OFF_EXTCTL, 8'hcc);
    @(posedge sys_clk) #1 chk({7'h0, dma_oe}, 8'h01);
    @(posedge sys_clk) ecp_enable <= 1'b0;
    rc(OFF_EXTCTL, 8'hff);
    test_done;
  end
endmodule // tb

// ===== hw/ecp_parallel_port_registers.sv
// Purpose: register set, fifo and cycle engine of an extended-capabilities parallel port
// Assumes: host strobes and pins synchronous to sys_clk; one access per cycle at most
// Notes:   read data appears one cycle after the read strobe, two on a stretched read; dma cycles ignore host_addr
`timescale 1ns/1ps

// Functional notes
// RQ1: port data reads return live data pin levels, not the write latch
// RQ2: command-tag port pushes tagged byte forward; backward writes dropped; reads undefined
// RQ3: status register mirrors legacy status, bit 2 reserved, writes ignored
// RQ4: control bit 5 is direction; forward drives data pins, backward releases them
// RQ5: control bits read back from the write latch, never from pins
// RQ6: control bit 4 enables ack interrupt; clearing drops pending request in level mode
// RQ7: control bits 0 and 1 hand strobe/autofeed to hardware or force low
// RQ8: compat fifo port is write-only, pushes data-tagged bytes from host or dma
// RQ9: forward data fifo port pushes data-tagged bytes; reads undefined
// RQ10: backward mode runs peripheral reads to fill fifo; host reads pop; writes ignored
// RQ11: test mode pushes and pops in either direction, no cycles, overflow ignored
// RQ12: config a reads 0001x100 only in mode 111, x from setup bit 5
// RQ13: config b shows irq level, line select, fixed bits and two setup bits
// RQ14: extended control register resets to 00010101
// RQ15: extended control read with stale status bits holds the ready line low
// RQ16: modes 000/001 software cycles, open-drain, fifo empty; 000 forces forward
// RQ17: mode 010 hardware writes, forward forced; push-pull when config bit 1 set
// RQ18: mode 011 direction from control bit 5, hardware strobe/autofeed, push-pull
// RQ19: fault falling edge or unmask while fault low interrupts when bit 4 clear
// RQ20: bit 3 clear disables dma, floats request, ignores grant; set allows dma
// RQ21: service bit clear lets tc or threshold events interrupt and set it
// RQ22: full and empty bits read-only and live; frozen clock reads 1,1 and service 0
// RQ23: whole function active only while port config bit 2 is set; the falling fault-edge interrupt is not gated by it
// RQ24: unreachable register access does nothing and leaves fifo unchanged
// RQ25: reserved modes 100/101 issue no cycles or dma and hold fifo reset
module ecp_parallel_port_registers
  import ecp_port_pkg::*;
#(
  parameter int DEPTH     = FIFO_DEPTH,
  parameter int THRESHOLD = FIFO_THRESHOLD,
  parameter int BURST_MAX = DMA_BURST_MAX
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // host register port
  input  wire logic [2:0]   host_addr,
  input  wire logic         host_rd,
  input  wire logic         host_wr,
  input  wire logic [7:0]   host_wdata,
  output logic [7:0]        host_rdata,
  output logic              iochrdy_low,
  // dma handshake
  input  wire logic         port_dma_grant,
  input  wire logic         dma_tc,
  output logic              port_dma_request,
  output logic              port_dma_request_oe,
  // configuration levels from the setup registers
  input  wire logic         ecp_enable,
  input  wire logic         port_cfg_push_pull,
  input  wire logic         port_cfg_level_irq,
  input  wire logic         aux_setup_bit5,
  input  wire logic [1:0]   setup_config_one,
  input  wire logic         irq_line_five_sel,
  input  wire logic         irq_pin_level,
  input  wire logic         clk_frozen,
  // peripheral pins
  input  wire logic [7:0]   port_data_pins_in,
  output logic [7:0]        port_data_pins_out,
  output logic              port_data_pins_oe,
  input  status_pins_t      status_in,
  output ctl_pins_t         ctl_out,
  output ctl_pins_t         ctl_oe,
  // interrupt events
  output logic              ecp_irq_pulse,
  output logic              ack_irq_pending
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][8:0] mem;
    logic [PW-1:0]         wp;
    logic [PW-1:0]         rp;
    logic [CW-1:0]         count;
    engine_state_t         st;
    logic [8:0]            cur;
    logic [6:0]            rlc;
    logic                  rle_armed;
    logic [3:0]            tmr;
    logic [7:0]            data_lat;
    logic [5:0]            dev_ctl;
    logic [7:0]            ext_ctl;    // bits 1:0 hold the registered flag copy
    logic                  fault_n_prev;
    logic                  ack_n_prev;
    logic                  ack_pend;
    logic [7:0]            burst;
    logic                  rd_pend;
    logic [7:0]            rdata;
    logic [7:0]            pd_out;
    logic                  pd_oe;
    ctl_pins_t             pin_lvl;
    ctl_pins_t             pin_oe;
    logic                  dma_req;
    logic                  dma_oe;
    logic                  irq_pulse;
    logic                  rdy_low;
  } state_t;

  // RQ14: reset image
  localparam state_t RESET_STATE = '{
    st: ENG_IDLE, ext_ctl: EXTCTL_RESET, dev_ctl: DEVCTL_RESET, data_lat: DATA_RESET,
    fault_n_prev: 1'b1, ack_n_prev: 1'b1, pin_lvl: '1, rdata: UNDEF_READ, default: '0};

  // modes in which the fifo is alive
  function automatic logic fifo_mode_f(input mode_t m);
    return (m == MODE_COMPAT) || (m == MODE_ECP) || (m == MODE_TEST);
  endfunction

  // modes in which hardware runs peripheral cycles
  function automatic logic hw_mode_f(input mode_t m);
    return (m == MODE_COMPAT) || (m == MODE_ECP);
  endfunction

  state_t        s_q;
  state_t        s_d;
  mode_t         mode;
  logic          live;
  logic          dir;
  logic          full;
  logic          empty;
  logic          fwd_busy;
  logic [1:0]    live_flags;
  logic          dma_on;
  logic          dma_cyc;
  logic          pio_rd;
  logic          pio_wr;
  logic [2:0]    rd_addr;
  logic          host_push;
  logic          host_pop;
  logic          eng_push;
  logic          eng_pop;
  logic [8:0]    pdat;
  logic          push_ok;
  logic          pop_ok;
  logic [7:0]    head;
  logic [7:0]    rd_val;
  logic [7:0]    ext_view;
  logic [CW-1:0] free;
  logic          thr_ev;
  logic          svc_set;
  logic          err_ev;
  logic          ack_ev;
  logic          dma_want;
  logic          stb_on;
  logic          afd_on;
  logic          push_pull;

  always_comb begin
    s_d = s_q;
    // RQ23: everything but the falling fault-edge interrupt gated by the enable from the port config
    mode       = mode_t'(s_q.ext_ctl[EXT_MODE_LSB +: 3]);
    live       = ecp_enable & ~clk_frozen;
    // RQ16: modes 000 and 010 assume forward regardless of bit 5
    dir        = (mode == MODE_STD || mode == MODE_COMPAT) ? 1'b0 : s_q.dev_ctl[DEV_DIR_BIT];
    full       = s_q.count == CW'(DEPTH);
    empty      = s_q.count == '0;
    free       = CW'(DEPTH) - s_q.count;
    fwd_busy   = s_q.st inside {ENG_FWD_SETUP, ENG_FWD_STROBE, ENG_FWD_HOLD};
    // empty only once the forward cycle has finished
    live_flags = {full, empty & ~fwd_busy};
    head       = s_q.mem[s_q.rp][7:0];
    // RQ20: grant ignored and request floated while dma is disabled
    dma_on     = ecp_enable & s_q.ext_ctl[EXT_DMAEN_BIT];
    dma_cyc    = dma_on & port_dma_grant & (host_rd | host_wr);
    pio_rd     = ecp_enable & host_rd & ~(dma_on & port_dma_grant);
    pio_wr     = ecp_enable & host_wr & ~(dma_on & port_dma_grant);
    rd_addr    = dma_cyc ? OFF_FIFO : host_addr;
    host_push  = 1'b0;
    host_pop   = 1'b0;
    eng_push   = 1'b0;
    eng_pop    = 1'b0;
    pdat       = '0;
    err_ev     = 1'b0;
    ack_ev     = 1'b0;

    // RQ24: fifo ports act only in their own mode and direction
    if (live && ((pio_wr && host_addr == OFF_FIFO) || (dma_cyc && host_wr))) begin
      // RQ8: compat port pushes data-tagged bytes
      if (mode == MODE_COMPAT) begin
        host_push = 1'b1;
      end
      // RQ9: forward data port pushes data-tagged bytes
      if (mode == MODE_ECP && !dir) begin
        host_push = 1'b1;
      end
      // RQ11: test port pushes in either direction
      if (mode == MODE_TEST) begin
        host_push = 1'b1;
      end
      pdat = {TAG_DATA, host_wdata};
    end
    // RQ2: command-tag port pushes only forward in mode 011
    if (live && pio_wr && host_addr == OFF_DATA && mode == MODE_ECP && !dir) begin
      host_push = 1'b1;
      pdat      = {TAG_CMD, host_wdata};
    end
    // RQ10: backward data port reads pop; RQ11: test port pops either way
    if (live && ((pio_rd && host_addr == OFF_FIFO) || (dma_cyc && host_rd))) begin
      host_pop = (mode == MODE_ECP && dir) || (mode == MODE_TEST);
    end

    // RQ22: frozen clock overrides the service and flag bits on read
    ext_view = {s_q.ext_ctl[7:3],
                s_q.ext_ctl[EXT_SERVICE_BIT] & ~clk_frozen,
                s_q.ext_ctl[EXT_FULL_BIT] | clk_frozen,
                s_q.ext_ctl[EXT_EMPTY_BIT] | clk_frozen};

    // read multiplexer
    rd_val = UNDEF_READ;
    case (rd_addr)
      // RQ1: live pin levels, not the latch
      OFF_DATA: begin
        if (mode == MODE_STD || mode == MODE_BIDIR) begin
          rd_val = port_data_pins_in;
        end
      end
      // RQ3: legacy status image with bit 2 reserved
      OFF_STATUS: begin
        rd_val = {~status_in.busy, status_in.ack_n, status_in.paper_end,
                  status_in.selected, status_in.fault_n, 3'b000};
      end
      // RQ5: control bits from the latch
      OFF_CONTROL: begin
        rd_val = {DEVCTL_RSVD_RD, s_q.dev_ctl};
      end
      OFF_FIFO: begin
        if (host_pop && !empty) begin
          rd_val = head;
        end else if (mode == MODE_CONFIG) begin
          // RQ12: fixed image with one live setup bit
          rd_val                 = CONFIG_A_FIXED;
          rd_val[CFGA_SETUP_BIT] = aux_setup_bit5;
        end
      end
      OFF_CFGB: begin
        // RQ13: line select, pin level and two setup bits
        if (mode == MODE_CONFIG) begin
          rd_val                           = CONFIG_B_FIXED | {6'h00, setup_config_one};
          rd_val[CFGB_IRQ_BIT]             = irq_pin_level;
          rd_val[CFGB_LINE_LSB +: 2]       = {2{irq_line_five_sel}};
        end
      end
      OFF_EXTCTL: begin
        rd_val = ext_view;
      end
      default: rd_val = UNDEF_READ;
    endcase

    // RQ15: stale flags stretch the read by one cycle
    s_d.rdy_low = 1'b0;
    s_d.rd_pend = 1'b0;
    if (s_q.rd_pend) begin
      s_d.rdata = ext_view;
    end else if (pio_rd && host_addr == OFF_EXTCTL && s_q.ext_ctl[1:0] != live_flags) begin
      s_d.rdy_low = 1'b1;
      s_d.rd_pend = 1'b1;
    end else if (host_rd) begin
      s_d.rdata = ecp_enable ? rd_val : UNDEF_READ;  // refused while disabled
    end

    // register writes
    if (pio_wr && host_addr == OFF_DATA && (mode == MODE_STD || mode == MODE_BIDIR)) begin
      s_d.data_lat = host_wdata;
    end
    if (pio_wr && host_addr == OFF_CONTROL) begin
      // RQ4: direction bit is plain read/write
      s_d.dev_ctl = host_wdata[5:0];
      // RQ6: clearing the enable drops a pending level request
      if (port_cfg_level_irq && !host_wdata[DEV_ACKIRQ_BIT]) begin
        s_d.ack_pend = 1'b0;
      end
    end
    if (pio_wr && host_addr == OFF_EXTCTL) begin
      // RQ22: flag bits ignore writes
      s_d.ext_ctl[7:2] = host_wdata[7:2];
      // RQ19: unmasking while fault is low still interrupts
      if (s_q.ext_ctl[EXT_ERRMASK_BIT] && !host_wdata[EXT_ERRMASK_BIT]
          && !status_in.fault_n && !clk_frozen) begin
        err_ev = 1'b1;
      end
    end
    s_d.ext_ctl[1:0] = live_flags;

    // RQ19: falling fault edge while unmasked
    s_d.fault_n_prev = status_in.fault_n;
    if (s_q.fault_n_prev && !status_in.fault_n && !s_q.ext_ctl[EXT_ERRMASK_BIT]
        && !clk_frozen) begin
      err_ev = 1'b1;
    end

    // RQ6: ack deassertion sets the pending request, set beats clear
    s_d.ack_n_prev = status_in.ack_n;
    if (!s_q.ack_n_prev && status_in.ack_n && s_q.dev_ctl[DEV_ACKIRQ_BIT] && ecp_enable) begin
      ack_ev       = 1'b1;
      s_d.ack_pend = 1'b1;
    end else if (pio_rd && host_addr == OFF_STATUS) begin
      s_d.ack_pend = 1'b0;  // status read acknowledges
    end

    // RQ21: threshold and terminal-count service events
    thr_ev = live && !s_q.ext_ctl[EXT_DMAEN_BIT] && fifo_mode_f(mode) &&
             (dir ? (s_q.count >= CW'(THRESHOLD)) : (free >= CW'(THRESHOLD)));
    svc_set = !s_q.ext_ctl[EXT_SERVICE_BIT] && (thr_ev || (dma_cyc && dma_tc && !clk_frozen));
    if (svc_set) begin
      s_d.ext_ctl[EXT_SERVICE_BIT] = 1'b1;  // wins over a same-cycle write of 0
    end
    s_d.irq_pulse = svc_set | err_ev | ack_ev;

    // peripheral cycle engine
    s_d.tmr = s_q.tmr;
    case (s_q.st)
      ENG_IDLE: begin
        // RQ17: forward writes in 010/011; frozen clock starts no cycle
        if (live && hw_mode_f(mode) && !dir && !empty) begin
          eng_pop = 1'b1;
          s_d.cur = s_q.mem[s_q.rp];
          s_d.st  = ENG_FWD_SETUP;
        // RQ10: backward reads only while room remains
        end else if (live && mode == MODE_ECP && dir && !full) begin
          s_d.st = ENG_BWD_REQ;
        end
      end
      ENG_FWD_SETUP: begin
        if (!status_in.busy) begin
          s_d.st  = ENG_FWD_STROBE;
          s_d.tmr = STROBE_CYCLES;
        end
      end
      ENG_FWD_STROBE: begin
        // mode 010 times the strobe, 011 waits for busy
        if (mode == MODE_COMPAT) begin
          s_d.tmr = s_q.tmr - 4'h1;
          if (s_q.tmr <= 4'h1) begin
            s_d.st = ENG_FWD_HOLD;
          end
        end else if (status_in.busy) begin
          s_d.st = ENG_FWD_HOLD;
        end
      end
      ENG_FWD_HOLD: begin
        if (!status_in.busy) begin
          s_d.st = ENG_IDLE;
        end
      end
      ENG_BWD_REQ: begin
        if (!status_in.ack_n) begin
          s_d.st = ENG_BWD_ACK;
        end
      end
      ENG_BWD_ACK: begin
        if (status_in.ack_n) begin
          s_d.st = ENG_BWD_LATCH;
        end
      end
      ENG_BWD_LATCH: begin
        // data byte, or byte following a run count
        if (s_q.rle_armed || status_in.busy) begin
          s_d.cur       = {TAG_DATA, port_data_pins_in};
          s_d.rlc       = s_q.rle_armed ? s_q.rlc : 7'h00;
          s_d.rle_armed = 1'b0;
          s_d.st        = ENG_RLE_PUSH;
        end else begin
          if (!port_data_pins_in[7]) begin
            s_d.rlc       = port_data_pins_in[6:0];
            s_d.rle_armed = 1'b1;
          end
          s_d.st = ENG_IDLE;
        end
      end
      ENG_RLE_PUSH: begin
        // full is checked before every expanded push
        if (!full) begin
          eng_push = 1'b1;
          pdat     = s_q.cur;
          if (s_q.rlc == 7'h00) begin
            s_d.st = ENG_IDLE;
          end else begin
            s_d.rlc = s_q.rlc - 7'h01;
          end
        end
      end
      default: s_d.st = ENG_IDLE;
    endcase

    // fifo update; ignored overflow/underflow leaves flags alone
    push_ok = (host_push | eng_push) & ~full;
    pop_ok  = (host_pop | eng_pop) & ~empty;
    if (push_ok) begin
      s_d.mem[s_q.wp] = pdat;
      s_d.wp          = s_q.wp + PW'(1);
    end
    if (pop_ok) begin
      s_d.rp = s_q.rp + PW'(1);
    end
    s_d.count = s_q.count + CW'(push_ok) - CW'(pop_ok);

    // RQ25: reserved, software and config modes hold the fifo reset
    if (!ecp_enable || !fifo_mode_f(mode)) begin
      s_d.wp    = '0;
      s_d.rp    = '0;
      s_d.count = '0;
    end
    // leaving 010/011 aborts any cycle or pending run expansion
    if (!ecp_enable || !hw_mode_f(mode)) begin
      s_d.st        = ENG_IDLE;
      s_d.rle_armed = 1'b0;
    end

    // RQ20: dma request with a forced gap after a long burst
    dma_want = dma_on && !s_q.ext_ctl[EXT_SERVICE_BIT] && !clk_frozen && fifo_mode_f(mode)
               && (dir ? !empty : !full) && (s_q.burst != 8'(BURST_MAX));
    if (!dma_want) begin
      s_d.burst = 8'h00;
    end else if (dma_cyc) begin
      s_d.burst = s_q.burst + 8'h01;
    end
    s_d.dma_req = dma_want;
    s_d.dma_oe  = dma_on;

    // RQ7: hardware strobe/autofeed unless the control bits force them low
    stb_on = s_q.dev_ctl[DEV_STROBE_BIT] | (hw_mode_f(mode) && s_q.st == ENG_FWD_STROBE);
    afd_on = s_q.dev_ctl[DEV_AFEED_BIT] | (mode == MODE_ECP &&
             ((fwd_busy && s_q.cur[8] == TAG_CMD) || s_q.st == ENG_BWD_REQ));
    s_d.pin_lvl = '{strobe: ~stb_on, autofeed: ~afd_on,
                    init: s_q.dev_ctl[DEV_INIT_BIT], select: ~s_q.dev_ctl[DEV_SELECT_BIT]};
    // RQ16: open-drain by default; RQ17: push-pull in 010 with config bit; RQ18: 011
    push_pull = (mode == MODE_ECP) || (mode == MODE_COMPAT && port_cfg_push_pull);
    s_d.pin_oe = '{strobe:   ecp_enable & (push_pull | ~s_d.pin_lvl.strobe),
                   autofeed: ecp_enable & (push_pull | ~s_d.pin_lvl.autofeed),
                   init:     ecp_enable & (push_pull | ~s_d.pin_lvl.init),
                   select:   ecp_enable & (push_pull | ~s_d.pin_lvl.select)};
    // RQ4: data pins driven forward, released backward
    s_d.pd_oe  = ecp_enable & ~dir;
    s_d.pd_out = fwd_busy ? s_q.cur[7:0] : s_q.data_lat;
  end

  // single state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign host_rdata          = s_q.rdata;
  assign iochrdy_low         = s_q.rdy_low;
  assign port_dma_request    = s_q.dma_req;
  assign port_dma_request_oe = s_q.dma_oe;
  assign port_data_pins_out  = s_q.pd_out;
  assign port_data_pins_oe   = s_q.pd_oe;
  assign ctl_out             = s_q.pin_lvl;
  assign ctl_oe              = s_q.pin_oe;
  assign ecp_irq_pulse       = s_q.irq_pulse;
  assign ack_irq_pending     = s_q.ack_pend;

endmodule // ecp_parallel_port_registers

// ===== hw/ecp_port_pkg.sv
// Purpose: shared constants and types for the extended-capabilities parallel port registers
// Assumes: byte-wide host register port, offsets 0..5 as decoded by the host address logic
// Notes:   field positions refer to the 8-bit register images seen by the host
package ecp_port_pkg;

  // register offsets on the host port
  localparam logic [2:0] OFF_DATA    = 3'h0;  // port data / command-tag fifo
  localparam logic [2:0] OFF_STATUS  = 3'h1;
  localparam logic [2:0] OFF_CONTROL = 3'h2;
  localparam logic [2:0] OFF_FIFO    = 3'h3;  // compat / data / test fifo, config a
  localparam logic [2:0] OFF_CFGB    = 3'h4;
  localparam logic [2:0] OFF_EXTCTL  = 3'h5;

  // reset values and fixed read images
  localparam logic [7:0] EXTCTL_RESET   = 8'h15;
  localparam logic [5:0] DEVCTL_RESET   = 6'h00;
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam logic [7:0] UNDEF_READ     = 8'hff;
  localparam logic [1:0] DEVCTL_RSVD_RD = 2'b11;
  localparam logic [7:0] CONFIG_A_FIXED = 8'h14;  // 0001x100 with x cleared
  localparam logic [7:0] CONFIG_B_FIXED = 8'h08;

  // extended control register fields
  localparam int EXT_MODE_LSB    = 5;
  localparam int EXT_ERRMASK_BIT = 4;
  localparam int EXT_DMAEN_BIT   = 3;
  localparam int EXT_SERVICE_BIT = 2;
  localparam int EXT_FULL_BIT    = 1;
  localparam int EXT_EMPTY_BIT   = 0;

  // device control register fields
  localparam int DEV_STROBE_BIT = 0;
  localparam int DEV_AFEED_BIT  = 1;
  localparam int DEV_INIT_BIT   = 2;
  localparam int DEV_SELECT_BIT = 3;
  localparam int DEV_ACKIRQ_BIT = 4;
  localparam int DEV_DIR_BIT    = 5;

  // config register fields
  localparam int CFGA_SETUP_BIT = 3;
  localparam int CFGB_IRQ_BIT   = 6;
  localparam int CFGB_LINE_LSB  = 4;

  // fifo, dma and cycle counts
  localparam int         FIFO_DEPTH     = 16;
  localparam int         FIFO_THRESHOLD = 8;
  localparam int         DMA_BURST_MAX  = 32;
  localparam logic [3:0] STROBE_CYCLES  = 4'h2;
  localparam logic       TAG_CMD        = 1'b1;
  localparam logic       TAG_DATA       = 1'b0;

  typedef enum logic [2:0] {
    MODE_STD    = 3'b000, MODE_BIDIR  = 3'b001, MODE_COMPAT = 3'b010, MODE_ECP = 3'b011,
    MODE_RSVD4  = 3'b100, MODE_RSVD5  = 3'b101, MODE_TEST   = 3'b110, MODE_CONFIG = 3'b111
  } mode_t;

  typedef enum logic [7:0] {
    ENG_IDLE   = 8'h01, ENG_FWD_SETUP = 8'h02, ENG_FWD_STROBE = 8'h04, ENG_FWD_HOLD = 8'h08,
    ENG_BWD_REQ = 8'h10, ENG_BWD_ACK  = 8'h20, ENG_BWD_LATCH  = 8'h40, ENG_RLE_PUSH = 8'h80
  } engine_state_t;

  // control pins, each field is the pin level (strobe, autofeed, select active low)
  typedef struct packed {
    logic strobe;
    logic autofeed;
    logic init;
    logic select;
  } ctl_pins_t;

  // status pins as sensed
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_end;
    logic selected;
    logic fault_n;
  } status_pins_t;

endpackage
